/* rtl/dqvref_ctrl.sv */
/*
 * data-lane reference voltage control: holds the reference step and range,
 * the fast-settle enable, answers mode register reads, converts the code to
 * a reference level and times the settling after each change.
 * assumes mode register write and read strobes last one cycle and are
 * synchronous to the 40 MHz command clock.
 */
`default_nettype none

// Overview of operation
// - reference register holds six-bit step in low bits, range bit just above
// - range 0 spans 10 % to 30 % of the i/o supply
// - range 1 spans 22 % to 42 % of the i/o supply
// - each step unit moves the reference by 0.4 % of the supply
// - single-step change settles within 100 ns
// - multi-step change within one range settles within 200 ns
// - minimum-to-maximum change settles within 250 ns
// - with fast settle off any change may take 1 ms
// - read command fetches a mode register, write command updates it
// - after fast-settle enable only deselects for 200 ns
module dqvref_ctrl #(
	parameter int unsigned SETTLE_WEAK_CYC = dqvref_pkg::WEAK_CYC
) (
	input  wire logic                           clk_sys_i,
	input  wire logic                           srst_i,
	input  wire logic                           mr_write_i,
	input  wire logic                           mrr_i,
	input  wire logic [dqvref_pkg::MR_ADDR_W-1:0] mr_addr_i,
	input  wire logic [dqvref_pkg::MR_DATA_W-1:0] mr_wdata_i,
	output var  logic [dqvref_pkg::MR_DATA_W-1:0] mrr_data_o,
	output var  logic                           mrr_valid_o,
	output var  logic [dqvref_pkg::STEP_W-1:0]  vref_step_o,
	output var  logic                           vref_range_o,
	output var  logic [dqvref_pkg::LEVEL_W-1:0] vref_level_o,
	output var  logic                           fast_settle_o,
	output var  logic                           vref_settling_o,
	output var  logic                           cmd_violation_o
);
	import dqvref_pkg::*;

	typedef struct packed {
		logic [STEP_W-1:0]    step;
		logic                 range;
		logic [LEVEL_W-1:0]   level;
		logic                 fast;
		logic [FS_CNT_W-1:0]  fs_cnt;
		logic [MR_DATA_W-1:0] rdata;
		logic                 rvalid;
		logic                 viol;
	} dqvref_st_type;

	dqvref_st_type     st_ff;
	dqvref_st_type     nxt_st;
	dqvref_settle_type settle_class;
	logic              wr_vref;
	logic              wr_freq;
	logic [STEP_W-1:0] new_step;
	logic              new_range;
	logic [STEP_W-1:0] step_dist;
	logic              tmr_load;
	logic [CNT_W-1:0]  tmr_count;
	logic              tmr_busy;

	////////////////////////////////////////////////////////////////////////
	// command decode and field extraction
	assign wr_vref   = mr_write_i && (mr_addr_i == MR_ADDR_DQ_VREF);
	assign wr_freq   = mr_write_i && (mr_addr_i == MR_ADDR_FREQ_TRN);
	assign new_step  = mr_wdata_i[STEP_LSB +: STEP_W];
	assign new_range = mr_wdata_i[RANGE_BIT];
	assign step_dist = (new_step > st_ff.step) ? (new_step - st_ff.step) : (st_ff.step - new_step);

	// classify the update; with fast settle on, a range switch is treated as a long change
	always_comb begin
		settle_class = SETTLE_NONE;
		if (!wr_vref || (new_step == st_ff.step && new_range == st_ff.range)) begin
			settle_class = SETTLE_NONE;
		end else if (!st_ff.fast) begin
			settle_class = SETTLE_WEAK;
		end else if (new_range != st_ff.range) begin
			settle_class = SETTLE_LONG;
		end else if (step_dist == STEP_W'(1)) begin
			settle_class = SETTLE_SHORT;
		end else if (step_dist >= FULL_SPAN_STEPS) begin
			settle_class = SETTLE_LONG;
		end else begin
			settle_class = SETTLE_MIDDLE;
		end
	end

	// settle time per class
	always_comb begin
		tmr_load  = (settle_class != SETTLE_NONE);
		tmr_count = '0;
		case (settle_class)
			SETTLE_SHORT:  tmr_count = CNT_W'(SHORT_CYC);
			SETTLE_MIDDLE: tmr_count = CNT_W'(MIDDLE_CYC);
			SETTLE_LONG:   tmr_count = CNT_W'(LONG_CYC);
			SETTLE_WEAK:   tmr_count = CNT_W'(SETTLE_WEAK_CYC);
			default:       tmr_count = '0;
		endcase
	end

	// flag stays up while the reference is still moving
	dqvref_settle_timer u_settle (
		.clk_sys_i (clk_sys_i),
		.srst_i    (srst_i),
		.load_i    (tmr_load),
		.count_i   (tmr_count),
		.busy_o    (tmr_busy)
	);

	////////////////////////////////////////////////////////////////////////
	// next state: registers, level, read answer, protocol checks
	always_comb begin
		nxt_st        = st_ff;
		nxt_st.rvalid = 1'b0;
		nxt_st.viol   = 1'b0;
		if (st_ff.fs_cnt != '0) begin
			nxt_st.fs_cnt = st_ff.fs_cnt - FS_CNT_W'(1);
		end
		if (wr_vref) begin
			nxt_st.step  = new_step;
			nxt_st.range = new_range;
		end
		if (wr_freq && (mr_wdata_i[FAST_SETTLE_BIT] != st_ff.fast)) begin
			nxt_st.fast   = mr_wdata_i[FAST_SETTLE_BIT];
			// only deselects may follow until the generator has switched
			nxt_st.fs_cnt = mr_wdata_i[FAST_SETTLE_BIT] ? FS_CNT_W'(FS_ENABLE_CYC) : FS_CNT_W'(FS_DISABLE_CYC);
		end
		// level = base of range + step * 0.4 %, in 0.1 % units
		nxt_st.level = (nxt_st.range ? LEVEL_BASE_R1 : LEVEL_BASE_R0)
			+ LEVEL_W'({nxt_st.step, 2'b00});
		if (mrr_i) begin
			nxt_st.rvalid = 1'b1;
			if (mr_addr_i == MR_ADDR_DQ_VREF) begin
				nxt_st.rdata = {1'b0, st_ff.range, st_ff.step};
			end else if (mr_addr_i == MR_ADDR_FREQ_TRN) begin
				nxt_st.rdata = MR_DATA_W'({st_ff.fast, 3'b000});
			end else begin
				nxt_st.rdata = '0; // other registers live elsewhere
			end
		end
		// early commands are flagged, not refused: the dram cannot stall
		if ((st_ff.fs_cnt != '0) && (mr_write_i || mrr_i)) begin
			nxt_st.viol = 1'b1;
		end
		if (wr_vref && tmr_busy) begin
			nxt_st.viol = 1'b1;
		end
	end

	// state register
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			st_ff        <= '0;
			st_ff.step   <= RST_STEP;
			st_ff.range  <= RST_RANGE;
			st_ff.fast   <= RST_FAST_SETTLE;
			st_ff.level  <= LEVEL_BASE_R0 + LEVEL_W'({RST_STEP, 2'b00});
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign mrr_data_o      = st_ff.rdata;
	assign mrr_valid_o     = st_ff.rvalid;
	assign vref_step_o     = st_ff.step;
	assign vref_range_o    = st_ff.range;
	assign vref_level_o    = st_ff.level;
	assign fast_settle_o   = st_ff.fast;
	assign vref_settling_o = tmr_busy;
	assign cmd_violation_o = st_ff.viol;

	////////////////////////////////////////////////////////////////////////
	// assertions
	property p_fields;
		@(posedge clk_sys_i) disable iff (srst_i)
		wr_vref |=> (vref_step_o == $past(mr_wdata_i[STEP_LSB +: STEP_W]))
			&& (vref_range_o == $past(mr_wdata_i[RANGE_BIT]));
	endproperty
	a_fields: assert property (p_fields) else $error("reference fields not taken from write");

	property p_range0;
		@(posedge clk_sys_i) disable iff (srst_i)
		(!vref_range_o && vref_step_o == FULL_SPAN_STEPS) |-> (vref_level_o == LEVEL_TOP_R0);
	endproperty
	a_range0: assert property (p_range0) else $error("range 0 top level wrong");

	property p_range1;
		@(posedge clk_sys_i) disable iff (srst_i)
		(vref_range_o && vref_step_o == 6'h00) |-> (vref_level_o == LEVEL_BASE_R1);
	endproperty
	a_range1: assert property (p_range1) else $error("range 1 base level wrong");

	property p_step;
		@(posedge clk_sys_i) disable iff (srst_i)
		(vref_range_o == $past(vref_range_o)) && $changed(vref_step_o) |->
			(int'(vref_level_o) - int'($past(vref_level_o))
			== int'(STEP_WEIGHT) * (int'(vref_step_o) - int'($past(vref_step_o))));
	endproperty
	a_step: assert property (p_step) else $error("level not moved by step weight");

	property p_short;
		@(posedge clk_sys_i) disable iff (srst_i)
		(settle_class == SETTLE_SHORT) |=> vref_settling_o [*4] ##1 !vref_settling_o;
	endproperty
	a_short: assert property (p_short) else $error("single-step settle time wrong");

	property p_middle;
		@(posedge clk_sys_i) disable iff (srst_i)
		(settle_class == SETTLE_MIDDLE) |=> vref_settling_o [*8] ##1 !vref_settling_o;
	endproperty
	a_middle: assert property (p_middle) else $error("multi-step settle time wrong");

	property p_long;
		@(posedge clk_sys_i) disable iff (srst_i)
		(settle_class == SETTLE_LONG) |=> vref_settling_o [*8] ##1 vref_settling_o [*2] ##1 !vref_settling_o;
	endproperty
	a_long: assert property (p_long) else $error("long settle time wrong");

	property p_weak;
		@(posedge clk_sys_i) disable iff (srst_i)
		wr_vref && !fast_settle_o && ({new_range, new_step} != {vref_range_o, vref_step_o})
			|-> (tmr_count == CNT_W'(SETTLE_WEAK_CYC)) ##1 vref_settling_o [*8];
	endproperty
	a_weak: assert property (p_weak) else $error("weak settle not applied");

	property p_read;
		@(posedge clk_sys_i) disable iff (srst_i)
		mrr_i && (mr_addr_i == MR_ADDR_DQ_VREF) && !mr_write_i |=>
			mrr_valid_o && (mrr_data_o == {1'b0, vref_range_o, vref_step_o}) ##1 !mrr_valid_o || $past(mrr_i);
	endproperty
	a_read: assert property (p_read) else $error("read answer wrong");

	property p_fs_window;
		@(posedge clk_sys_i) disable iff (srst_i)
		wr_freq && mr_wdata_i[FAST_SETTLE_BIT] && !fast_settle_o ##1 (mr_write_i || mrr_i) |=> cmd_violation_o;
	endproperty
	a_fs_window: assert property (p_fs_window) else $error("command in enable window not flagged");
endmodule

`default_nettype wire

/* rtl/dqvref_pkg.sv */
/*
 * constants, field layout and settle classes for the data-lane
 * reference voltage control block.
 * assumes a single 40 MHz command clock and mode register commands
 * presented as one-cycle strobes.
 */
`default_nettype none

package dqvref_pkg;
	////////////////////////////////////////////////////////////////////////
	// mode register addressing and field layout
	localparam int unsigned    MR_ADDR_W        = 6;
	localparam int unsigned    MR_DATA_W        = 8;
	localparam logic [5:0]     MR_ADDR_FREQ_TRN = 6'h0d; // frequency_and_training_control
	localparam logic [5:0]     MR_ADDR_DQ_VREF  = 6'h0e; // dq_reference_voltage_control
	localparam int unsigned    STEP_W           = 6;
	localparam int unsigned    STEP_LSB         = 0;
	localparam int unsigned    RANGE_BIT        = 6;
	localparam int unsigned    FAST_SETTLE_BIT  = 3;
	localparam logic [5:0]     RST_STEP         = 6'h0d;
	localparam logic           RST_RANGE        = 1'b0;
	localparam logic           RST_FAST_SETTLE  = 1'b0;

	////////////////////////////////////////////////////////////////////////
	// reference level, in tenths of a percent of the i/o supply
	localparam int unsigned    LEVEL_W          = 10;
	localparam logic [9:0]     LEVEL_BASE_R0    = 10'h064; // 10.0 %
	localparam logic [9:0]     LEVEL_BASE_R1    = 10'h0dc; // 22.0 %
	localparam logic [9:0]     LEVEL_TOP_R0     = 10'h12c; // 30.0 %
	localparam logic [9:0]     LEVEL_TOP_R1     = 10'h1a4; // 42.0 %
	localparam int unsigned    STEP_WEIGHT      = 4;       // 0.4 % per step
	localparam logic [5:0]     FULL_SPAN_STEPS  = 6'h32;   // 20 % / 0.4 %

	////////////////////////////////////////////////////////////////////////
	// timing: figures as printed, cycles derived (max times round down)
	localparam int unsigned    CLK_PERIOD_NS    = 25;
	localparam int unsigned    T_SHORT_NS       = 100;
	localparam int unsigned    T_MIDDLE_NS      = 200;
	localparam int unsigned    T_LONG_NS        = 250;
	localparam int unsigned    T_WEAK_MS        = 1;
	localparam int unsigned    T_FS_ENABLE_NS   = 200;
	localparam int unsigned    T_FS_DISABLE_NS  = 100;
	localparam int unsigned    NS_PER_MS        = 1000000;
	localparam int unsigned    SHORT_CYC        = T_SHORT_NS / CLK_PERIOD_NS;
	localparam int unsigned    MIDDLE_CYC       = T_MIDDLE_NS / CLK_PERIOD_NS;
	localparam int unsigned    LONG_CYC         = T_LONG_NS / CLK_PERIOD_NS;
	localparam int unsigned    WEAK_CYC         = T_WEAK_MS * NS_PER_MS / CLK_PERIOD_NS;
	localparam int unsigned    FS_ENABLE_CYC    = T_FS_ENABLE_NS / CLK_PERIOD_NS;
	localparam int unsigned    FS_DISABLE_CYC   = T_FS_DISABLE_NS / CLK_PERIOD_NS;
	localparam int unsigned    CNT_W            = 16;
	localparam int unsigned    FS_CNT_W         = 4;

	////////////////////////////////////////////////////////////////////////
	// settle classes of one reference update
	typedef enum logic [2:0] {
		SETTLE_NONE,
		SETTLE_SHORT,
		SETTLE_MIDDLE,
		SETTLE_LONG,
		SETTLE_WEAK
	} dqvref_settle_type;
endpackage

`default_nettype wire

/* rtl/dqvref_settle_timer.sv */
/*
 * down-counter that holds the settling flag for a loaded number of cycles.
 * assumes load_i is a one-cycle strobe; a new load restarts the count.
 */
`default_nettype none

module dqvref_settle_timer (
	input  wire logic                      clk_sys_i,
	input  wire logic                      srst_i,
	input  wire logic                      load_i,
	input  wire logic [dqvref_pkg::CNT_W-1:0] count_i,
	output var  logic                      busy_o
);
	import dqvref_pkg::*;

	typedef struct packed {
		logic [CNT_W-1:0] cnt;
		logic             busy;
	} dqvref_tmr_type;

	dqvref_tmr_type st_ff;
	dqvref_tmr_type nxt_st;

	////////////////////////////////////////////////////////////////////////
	// busy follows the next count so it rises on the load edge
	always_comb begin
		nxt_st = st_ff;
		if (load_i) begin
			nxt_st.cnt = count_i;
		end else if (st_ff.cnt != '0) begin
			nxt_st.cnt = st_ff.cnt - CNT_W'(1);
		end
		nxt_st.busy = (nxt_st.cnt != '0);
	end

	// state register
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign busy_o = st_ff.busy;
endmodule

`default_nettype wire

/* test/dqvref_ctrl_tb.sv */
/*
 * self-checking bench for the reference voltage control block.
 * assumes a 40 MHz clock and a shortened weak settle count of 50 cycles.
 */
`default_nettype none

module dqvref_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import dqvref_pkg::*;

	localparam int unsigned WEAK = 50;
	logic       clk_sys_i = 1'b0;
	logic       srst_i    = 1'b1;
	logic       mr_write, mrr, mrr_valid, vrange, fast, settling, viol;
	logic [5:0] addr, step;
	logic [7:0] wdata, mrr_data;
	logic [9:0] level;
	logic [7:0] rd_q[$];
	int         st_q[$];
	int         compares = 0;
	int         miscompares = 0;
	int         viol_n = 0;
	int         run_len = 0;
	int         cycles = 0;
	logic [7:0] pat[8] = '{8'h0e, 8'h14, 8'h00, 8'h32, 8'h72, 8'h40, 8'h40, 8'h41};

	dqvref_mc_model #(.WEAK(WEAK)) mc (.clk_sys_i(clk_sys_i), .mr_write_o(mr_write), .mrr_o(mrr),
		.mr_addr_o(addr), .mr_wdata_o(wdata));
	dqvref_ctrl #(.SETTLE_WEAK_CYC(WEAK)) uut (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
		.mr_write_i(mr_write), .mrr_i(mrr), .mr_addr_i(addr), .mr_wdata_i(wdata),
		.mrr_data_o(mrr_data), .mrr_valid_o(mrr_valid), .vref_step_o(step),
		.vref_range_o(vrange), .vref_level_o(level), .fast_settle_o(fast),
		.vref_settling_o(settling), .cmd_violation_o(viol));

	initial begin
		forever #12.5 clk_sys_i = ~clk_sys_i;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR %s expected %0h seen %0h", what, exp, got);
		end
	endtask

	task automatic final_report();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic rd_exp(input logic [5:0] a, input logic [7:0] e);
		rd_q.push_back(e);
		mc.rd(a);
	endtask

	// reference write with level, field and settle expectations
	task automatic vwr(input logic [7:0] d);
		int         n;
		logic [9:0] lv;
		n = mc.cyc(mc.cur, d[6:0]);
		if (n > 0) st_q.push_back(n);
		mc.wr(MR_ADDR_DQ_VREF, d, 1'b1);
		lv = (d[6] ? LEVEL_BASE_R1 : LEVEL_BASE_R0) + 10'(STEP_WEIGHT * d[5:0]);
		check("level", lv, level);
		check("step", d[5:0], step);
		check("range", d[6], vrange);
		rd_exp(MR_ADDR_DQ_VREF, {1'b0, d[6:0]});
	endtask

	////////////////////////////////////////////////////////////////////////
	// monitor on the falling edge, where registered outputs have settled
	always @(negedge clk_sys_i) begin
		cycles++;
		if (cycles == 5000) begin
			miscompares++;
			final_report();
		end
		if (mrr_valid === 1'b1) check("read data", rd_q.pop_front(), mrr_data);
		if (viol === 1'b1) viol_n++;
		if (settling === 1'b1) begin
			run_len++;
		end else if (run_len > 0) begin
			check("settle cycles", st_q.pop_front(), run_len);
			run_len = 0;
		end
	end

	// main sequence
	initial begin
		void'($urandom(83));
		repeat (4) @(negedge clk_sys_i);
		srst_i = 1'b0;
		check("reset level", LEVEL_BASE_R0 + 10'(STEP_WEIGHT * RST_STEP), level);
		rd_exp(MR_ADDR_DQ_VREF, {1'b0, RST_RANGE, RST_STEP});
		rd_exp(MR_ADDR_FREQ_TRN, 8'h00);
		rd_exp(6'h2a, 8'h00);
		$display("test reset done");
		mc.wr(MR_ADDR_FREQ_TRN, 8'h08, 1'b1);
		check("fast settle", 1'b1, fast);
		foreach (pat[i]) vwr(pat[i]);
		$display("test directed steps done");
		repeat (8) vwr({1'($urandom), 1'($urandom), 6'($urandom_range(0, 50))});
		$display("test random steps done");
		mc.wr(MR_ADDR_FREQ_TRN, 8'h00, 1'b1);
		// step 63 lies outside the random range, so this always moves
		vwr(8'h3f);
		$display("test weak settle done");
		mc.wr(MR_ADDR_FREQ_TRN, 8'h08, 1'b0);
		rd_exp(MR_ADDR_FREQ_TRN, 8'h08);
		repeat (12) @(negedge clk_sys_i);
		check("violations", 1, viol_n);
		$display("test switch window done");
		final_report();
	end
endmodule

`default_nettype wire

/* test/dqvref_mc_model.sv */
/*
 * controller-side model: issues mode register writes and reads and spaces
 * reference updates by the settle class of each change.
 * assumes the block samples strobes on the rising edge of clk_sys_i.
 */
`default_nettype none

module dqvref_mc_model #(
	parameter int unsigned WEAK = 50
) (
	input  wire logic                             clk_sys_i,
	output var  logic                             mr_write_o,
	output var  logic                             mrr_o,
	output var  logic [dqvref_pkg::MR_ADDR_W-1:0] mr_addr_o,
	output var  logic [dqvref_pkg::MR_DATA_W-1:0] mr_wdata_o
);
	timeunit 1ns;
	timeprecision 1ps;
	import dqvref_pkg::*;

	logic [6:0] cur  = {RST_RANGE, RST_STEP};
	logic       fast = RST_FAST_SETTLE;

	////////////////////////////////////////////////////////////////////////
	// idle lines before the first command
	initial begin
		mr_write_o = 1'b0;
		mrr_o = 1'b0;
		mr_addr_o = 6'h00;
		mr_wdata_o = 8'h00;
	end

	// settle class of one update; with fast settle on, range flips count as long
	function automatic int cyc(input logic [6:0] o, input logic [6:0] n);
		int d;
		d = (o[5:0] > n[5:0]) ? int'(o[5:0] - n[5:0]) : int'(n[5:0] - o[5:0]);
		if (o == n) return 0;
		if (!fast) return WEAK;
		if (o[6] != n[6] || d >= int'(FULL_SPAN_STEPS)) return LONG_CYC;
		return (d == 1) ? SHORT_CYC : MIDDLE_CYC;
	endfunction

	// one-cycle strobe; released lines flip so stale values never pass
	task automatic issue(input logic w, input logic [5:0] a, input logic [7:0] d);
		@(negedge clk_sys_i);
		mr_write_o = w;
		mrr_o = !w;
		mr_addr_o = a;
		mr_wdata_o = d;
		@(negedge clk_sys_i);
		mr_write_o = 1'b0;
		mrr_o = 1'b0;
		mr_addr_o = ~a;
		mr_wdata_o = ~d;
	endtask

	// write, then wait out the settle or switch window unless told to break it
	task automatic wr(input logic [5:0] a, input logic [7:0] d, input bit obey);
		int n;
		n = 0;
		issue(1'b1, a, d);
		if (a == MR_ADDR_DQ_VREF) begin
			n = cyc(cur, d[6:0]);
			cur = d[6:0];
		end else if (a == MR_ADDR_FREQ_TRN) begin
			n = d[3] ? FS_ENABLE_CYC : FS_DISABLE_CYC;
			fast = d[3];
		end
		if (obey) repeat (n + 2) @(negedge clk_sys_i);
	endtask

	task automatic rd(input logic [5:0] a);
		issue(1'b0, a, 8'h00);
	endtask
endmodule

`default_nettype wire
